// ### hw/sotp_pkg.sv
// Package: constants, types and opcode defaults of the secured OTP block
// Function
// - Enter-OTP switches to the 4K-bit OTP region and blocks main array access.
// - In OTP mode, read and page program address only the OTP region.
// - Opcodes take 8 clocks single-wire, lines 3..1 ignored, or 2 clocks quad.
// - Exit-OTP opcode framed alone returns the device to the main array.
// - After lock-down, OTP mode accepts reads only; programs are ignored.
// - Security read is served anytime, even busy, repeating while clocks run.
// - Security read drives the 8-bit value until chip select rises.
// - Security write only sets lock-down bit1; it never clears again.
// - Security write rejected unless chip select rises on a byte boundary.
// - Erase-fail bit6 set on erase failure, cleared on success, never stalls.
// - Program-fail bit5 set on failure or protected target, cleared on success.
// - Erase-suspended bit3 set on erase suspend, cleared on resume.
// - Program-suspended bit2 set on program suspend, cleared on resume.
// - Bit0 is read-only factory lock indicator.
// - One scheme at a time: bit7 zero block-range, one per-sector.
// - Protect-select after write enable sets bit7 forever.
// - Bit7 zero: array protection decided by block-range bits only.
// - Bit7 one: block-range bits ignored, sector lock commands enabled.
// - Per-sector: dynamic bits protect all at power-up; pin low protects all.
`default_nettype none
package sotp_pkg;
    // Security register bit positions
    localparam int BIT_FACTORY = 0;
    localparam int BIT_LOCKDOWN = 1;
    localparam int BIT_PSUSP = 2;
    localparam int BIT_ESUSP = 3;
    localparam int BIT_RSVD = 4;
    localparam int BIT_PFAIL = 5;
    localparam int BIT_EFAIL = 6;
    localparam int BIT_PROTECT_SCHEME_SELECT = 7;
    // Volatile reset values
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_RSVD = 1'b0;
    // Default opcodes, values arbitrary
    localparam logic [7:0] OPC_ENTER = 8'hA1;
    localparam logic [7:0] OPC_EXIT = 8'hA2;
    localparam logic [7:0] OPC_SREAD = 8'hA3;
    localparam logic [7:0] OPC_SWRITE = 8'hA4;
    localparam logic [7:0] OPC_PSEL = 8'hA5;
    // Bit advance per serial clock
    localparam logic [2:0] STEP_SPI = 3'h1;
    localparam logic [2:0] STEP_QPI = 3'h4;
    // Output enables of the I/O lines
    localparam logic [3:0] OE_SPI = 4'h2;
    localparam logic [3:0] OE_QPI = 4'hF;
    localparam int SYNC_W = 7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_OPC = 4'b0010,
        ST_RD = 4'b0100,
        ST_REST = 4'b1000
    } sotp_state_e;

    // Status events from the program/erase engine
    typedef struct packed {
        logic erase_fail;
        logic prog_fail;
        logic prog_prot;
        logic op_ok;
        logic erase_susp;
        logic erase_resume;
        logic prog_susp;
        logic prog_resume;
    } sotp_evt_s;

    // Non-volatile straps read back at power-up
    typedef struct packed {
        logic protect_scheme_select;
        logic lockdown;
        logic factory;
    } sotp_nv_s;
endpackage
`default_nettype wire

// ### hw/sotp_sync.sv
// Two-flop synchroniser for pins
`default_nettype none
module sotp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_i, // System clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic [W-1:0] d_i, // Asynchronous inputs
    output logic [W-1:0] q_o // Synchronised outputs
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff <= INIT;
            q_o <= INIT;
        end else begin
            meta_ff <= d_i;
            q_o <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ### hw/sotp_flag.sv
// Sticky status flag, set wins over clear
`default_nettype none
module sotp_flag #(
    parameter logic INIT = 1'b0
) (
    input wire logic clk_i, // System clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic set_i, // Set pulse
    input wire logic clr_i, // Clear pulse
    output logic q_o // Flag value
);
    logic nxt_q;

    // A set arriving with the clear is kept
    assign nxt_q = set_i | (q_o & ~clr_i);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q_o <= INIT;
        end else begin
            q_o <= nxt_q;
        end
    end
endmodule
`default_nettype wire

// ### hw/sotp_core.sv
// Secured OTP mode, security register and protect-select command logic
`default_nettype none
module sotp_core #(
    parameter logic [7:0] P_ENTER = sotp_pkg::OPC_ENTER,
    parameter logic [7:0] P_EXIT = sotp_pkg::OPC_EXIT,
    parameter logic [7:0] P_SREAD = sotp_pkg::OPC_SREAD,
    parameter logic [7:0] P_SWRITE = sotp_pkg::OPC_SWRITE,
    parameter logic [7:0] P_PSEL = sotp_pkg::OPC_PSEL
) (
    input wire logic clk_i, // 20 MHz clock
    input wire logic nrst_i, // Async reset, active low
    input wire logic cs_n_i, // Chip select pin, active low
    input wire logic sclk_i, // Serial clock pin
    input wire logic [3:0] sio_i, // I/O lines in
    output logic [3:0] sio_o, // I/O lines out
    output logic [3:0] sio_oe_o, // I/O line drive enables
    input wire logic wp_n_i, // Write-protect pin, active low
    input wire logic qpi_i, // Quad command mode active
    input wire logic wel_i, // Write-enable latch
    input wire sotp_pkg::sotp_evt_s evt_i, // Engine event pulses
    input wire sotp_pkg::sotp_nv_s nv_i, // Stored non-volatile bits
    input wire logic bp_hit_i, // Block-range bits protect target
    input wire logic sect_hit_i, // Sector lock bits protect target
    output logic otp_mode_o, // OTP region selected, array blocked
    output logic otp_prog_ok_o, // Programs to OTP region allowed
    output logic sect_cmd_en_o, // Sector lock commands active
    output logic array_wp_o, // Current target write protected
    output logic dyn_lock_all_o, // Pulse: set all dynamic lock bits
    output logic nv_prog_otp_lockdown_bit_o, // Pulse: store lock-down bit
    output logic nv_prog_protect_scheme_select_o, // Pulse: store scheme select bit
    output logic wel_clr_o, // Pulse: clear write-enable latch
    output logic [7:0] sec_reg_o // Security register value
);
    import sotp_pkg::*;

    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    logic [SYNC_W-1:0] pin_s;
    logic cs_s, sclk_s, wp_s;
    logic [3:0] sio_s;
    logic sclk_d_ff, cs_d_ff;

    // Reset levels match idle pins (cs high, clock low) so no false edge follows reset
    sotp_sync #(.W(SYNC_W), .INIT(7'h5F)) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({cs_n_i, sclk_i, wp_n_i, sio_i}),
        .q_o(pin_s)
    );

    assign {cs_s, sclk_s, wp_s, sio_s} = pin_s;

    // Delayed copies for edges
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_d_ff <= cs_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;
    wire cs_rise = cs_s & ~cs_d_ff;

    // ----------------------------------------
    // Frame tracking and opcode capture
    // ----------------------------------------
    sotp_state_e state_ff, nxt_state;
    logic [7:0] opc_ff, nxt_opc;
    logic [2:0] bitpos_ff;
    logic [1:0] bytes_ff;

    // Quad mode moves four bits a clock; single-wire reads line 0 only
    wire [2:0] step = qpi_i ? STEP_QPI : STEP_SPI;
    wire [3:0] pos_sum = {1'b0, bitpos_ff} + {1'b0, step};
    wire byte_done = pos_sum[3];
    wire in_opc = (state_ff == ST_OPC);
    assign nxt_opc = qpi_i ? {opc_ff[3:0], sio_s} : {opc_ff[6:0], sio_s[0]};
    wire opc_last = in_opc & sclk_rise & byte_done;

    // Next state of the frame walker
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (!cs_s) nxt_state = ST_OPC;
            ST_OPC: if (opc_last) nxt_state = (nxt_opc == P_SREAD) ? ST_RD : ST_REST;
            ST_RD: nxt_state = ST_RD;
            ST_REST: nxt_state = ST_REST;
            default: nxt_state = ST_IDLE;
        endcase
        if (cs_s) nxt_state = ST_IDLE;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Bit position in byte and saturating byte count
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bitpos_ff <= 3'h0;
            bytes_ff <= 2'h0;
            opc_ff <= 8'h00;
        end else if (state_ff == ST_IDLE) begin
            bitpos_ff <= 3'h0;
            bytes_ff <= 2'h0;
        end else if (sclk_rise) begin
            bitpos_ff <= pos_sum[2:0];
            if (byte_done && bytes_ff != 2'h3) bytes_ff <= bytes_ff + 2'h1;
            if (in_opc) opc_ff <= nxt_opc;
        end
    end

    // ----------------------------------------
    // Command decode at chip select rise
    // ----------------------------------------
    // Opcode-only commands need exactly one whole byte in the frame
    wire alone = cs_rise & (bytes_ff == 2'h1) & (bitpos_ff == 3'h0);
    wire boundary = cs_rise & (bytes_ff != 2'h0) & (bitpos_ff == 3'h0);
    wire do_enter = alone & (opc_ff == P_ENTER);
    wire do_exit = alone & (opc_ff == P_EXIT);
    wire do_swr = boundary & (opc_ff == P_SWRITE) & wel_i;
    wire do_psel = alone & (opc_ff == P_PSEL) & wel_i;

    // ----------------------------------------
    // Security register bits
    // ----------------------------------------
    logic loaded_ff, otp_ff, otp_lockdown_bit_ff, protect_scheme_select_ff, fact_ff;
    logic efail, pfail, esusp, psusp;

    // Straps are caught on the first clock after reset release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loaded_ff <= 1'b0;
            otp_lockdown_bit_ff <= 1'b0;
            protect_scheme_select_ff <= 1'b0;
            fact_ff <= 1'b0;
        end else if (!loaded_ff) begin
            loaded_ff <= 1'b1;
            otp_lockdown_bit_ff <= nv_i.lockdown;
            protect_scheme_select_ff <= nv_i.protect_scheme_select;
            fact_ff <= nv_i.factory;
        end else begin
            otp_lockdown_bit_ff <= otp_lockdown_bit_ff | do_swr;
            protect_scheme_select_ff <= protect_scheme_select_ff | do_psel;
        end
    end

    // OTP mode latch
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            otp_ff <= 1'b0;
        end else if (do_enter) begin
            otp_ff <= 1'b1;
        end else if (do_exit) begin
            otp_ff <= 1'b0;
        end
    end

    // Engine flags; none of them holds back any operation
    sotp_flag #(.INIT(RST_FLAG)) u_efail (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(evt_i.erase_fail),
        .clr_i(evt_i.op_ok),
        .q_o(efail)
    );
    sotp_flag #(.INIT(RST_FLAG)) u_pfail (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(evt_i.prog_fail | evt_i.prog_prot),
        .clr_i(evt_i.op_ok),
        .q_o(pfail)
    );
    sotp_flag #(.INIT(RST_FLAG)) u_esusp (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(evt_i.erase_susp),
        .clr_i(evt_i.erase_resume),
        .q_o(esusp)
    );
    sotp_flag #(.INIT(RST_FLAG)) u_psusp (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(evt_i.prog_susp),
        .clr_i(evt_i.prog_resume),
        .q_o(psusp)
    );

    // Register image; the reserved bit is a constant zero
    logic [7:0] sec_img;
    always_comb begin
        sec_img = 8'h00;
        sec_img[BIT_FACTORY] = fact_ff;
        sec_img[BIT_LOCKDOWN] = otp_lockdown_bit_ff;
        sec_img[BIT_PSUSP] = psusp;
        sec_img[BIT_ESUSP] = esusp;
        sec_img[BIT_RSVD] = RST_RSVD;
        sec_img[BIT_PFAIL] = pfail;
        sec_img[BIT_EFAIL] = efail;
        sec_img[BIT_PROTECT_SCHEME_SELECT] = protect_scheme_select_ff;
    end

    // ----------------------------------------
    // Security read shifter
    // ----------------------------------------
    logic [7:0] rd_sr_ff;
    logic [2:0] rd_pos_ff;
    // Each byte reloads the live image so a long read tracks busy flags
    wire [7:0] rd_cur = (rd_pos_ff == 3'h0) ? sec_img : rd_sr_ff;
    wire rd_shift = (state_ff == ST_RD) & sclk_fall & ~cs_s;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_sr_ff <= 8'h00;
            rd_pos_ff <= 3'h0;
            sio_o <= 4'h0;
            sio_oe_o <= 4'h0;
        end else if (state_ff != ST_RD || cs_s) begin
            rd_pos_ff <= 3'h0;
            sio_oe_o <= 4'h0;
        end else if (rd_shift) begin
            rd_pos_ff <= rd_pos_ff + step;
            if (qpi_i) begin
                sio_o <= rd_cur[7:4];
                rd_sr_ff <= {rd_cur[3:0], 4'h0};
                sio_oe_o <= OE_QPI;
            end else begin
                sio_o <= {2'b00, rd_cur[7], 1'b0};
                rd_sr_ff <= {rd_cur[6:0], 1'b0};
                sio_oe_o <= OE_SPI;
            end
        end
    end

    // ----------------------------------------
    // Protection and registered outputs
    // ----------------------------------------
    // Pin low in per-sector mode protects everything
    wire nxt_wp = protect_scheme_select_ff ? (sect_hit_i | ~wp_s) : bp_hit_i;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            otp_mode_o <= 1'b0;
            otp_prog_ok_o <= 1'b0;
            sect_cmd_en_o <= 1'b0;
            array_wp_o <= 1'b0;
            dyn_lock_all_o <= 1'b0;
            nv_prog_otp_lockdown_bit_o <= 1'b0;
            nv_prog_protect_scheme_select_o <= 1'b0;
            wel_clr_o <= 1'b0;
            sec_reg_o <= 8'h00;
        end else begin
            otp_mode_o <= otp_ff;
            otp_prog_ok_o <= otp_ff & ~otp_lockdown_bit_ff;
            sect_cmd_en_o <= protect_scheme_select_ff;
            array_wp_o <= nxt_wp;
            dyn_lock_all_o <= ~loaded_ff & nv_i.protect_scheme_select;
            nv_prog_otp_lockdown_bit_o <= do_swr & ~otp_lockdown_bit_ff;
            nv_prog_protect_scheme_select_o <= do_psel & ~protect_scheme_select_ff;
            wel_clr_o <= do_swr | do_psel;
            sec_reg_o <= sec_img;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_ENTER: assert property (do_enter |-> ##2 otp_mode_o)
        else $error("otp mode not entered");
    AST_EXIT: assert property (do_exit && !do_enter |-> ##2 !otp_mode_o)
        else $error("otp mode not left");
    AST_LOCK_PROG: assert property (otp_lockdown_bit_ff |=> !otp_prog_ok_o)
        else $error("otp program allowed after lock-down");
    AST_OTP_LOCKDOWN_BIT_STICKY: assert property (loaded_ff && otp_lockdown_bit_ff |=> otp_lockdown_bit_ff)
        else $error("lock-down bit cleared");
    AST_NOWEL_SWR: assert property (cs_rise && !wel_i |=> !wel_clr_o)
        else $error("write taken without write enable");
    AST_PROTECT_SCHEME_SELECT_STICKY: assert property (loaded_ff && protect_scheme_select_ff |=> protect_scheme_select_ff)
        else $error("scheme select returned to zero");
    AST_EFAIL: assert property (evt_i.erase_fail |=> efail)
        else $error("erase fail not set");
    AST_PFAIL: assert property (evt_i.prog_prot |=> pfail)
        else $error("program fail not set on protected target");
    AST_ESUSP: assert property (evt_i.erase_resume && !evt_i.erase_susp |=> !esusp)
        else $error("erase suspend not cleared");
    AST_PSUSP: assert property (evt_i.prog_susp |=> psusp ##1 sec_reg_o[BIT_PSUSP])
        else $error("program suspend not shown");
    AST_RSVD: assert property (sec_reg_o[BIT_RSVD] == 1'b0)
        else $error("reserved bit set");
    AST_WP_PIN: assert property (protect_scheme_select_ff && !wp_s |=> array_wp_o)
        else $error("pin low did not protect");
    AST_BP_ONLY: assert property (!protect_scheme_select_ff |=> array_wp_o == $past(bp_hit_i))
        else $error("block-range decision wrong");
    AST_RD_OE: assert property (cs_s |=> sio_oe_o == 4'h0)
        else $error("lines driven outside a read");

    COV_READ: cover property (rd_shift && rd_pos_ff == 3'h0 && bytes_ff == 2'h2);
    COV_OTP: cover property (do_enter ##[1:1000] do_exit);
    COV_PSEL: cover property (do_psel && !protect_scheme_select_ff);
endmodule
`default_nettype wire

// ### tb/sotp_host_model.sv
// Host flash controller model: frames opcodes and clocks read data in on the pins
`default_nettype none
module sotp_host_model (
    input wire logic clk_i, // System clock, paces the link
    input wire logic qpi_i, // Quad command mode
    input wire logic [3:0] sio_i, // Resolved I/O lines
    output logic cs_n_o, // Chip select, active low
    output logic sclk_o, // Serial clock, still outside frames
    output logic [3:0] sio_o // Host drive of the I/O lines
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins: chip select high, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sio_o = 4'h0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // One frame: opcode, extra junk clocks, then read clocks
    // ------------------------------------------------------------
    // Link period 8 clk: low 5, high 3; data sampled at the end of low
    // so the device has had its full answer latency after the fall.
    task automatic frame(input logic [7:0] opc, input int extra, input int nrd,
                         output logic [15:0] rd);
        int nop;
        logic [15:0] sh;
        nop = qpi_i ? 2 : 8;
        sh = 16'h0000;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        wait_n(3);
        for (int i = 0; i < nop + extra + nrd; i++) begin
            if (i < nop && qpi_i) begin
                sio_o = (i == 0) ? opc[7:4] : opc[3:0];
            end else if (i < nop) begin
                sio_o = {~sio_o[3:1], opc[7 - i]};
            end else begin
                sio_o = ~sio_o; // Released lines toggle, no stale value
            end
            sclk_o = 1'b0;
            wait_n(5);
            if (i >= nop + extra && qpi_i) begin
                sh = {sh[11:0], sio_i};
            end else if (i >= nop + extra) begin
                sh = {sh[14:0], sio_i[1]};
            end
            sclk_o = 1'b1;
            wait_n(3);
        end
        sclk_o = 1'b0;
        wait_n(2);
        cs_n_o = 1'b1;
        sio_o = ~sio_o;
        rd = sh;
        wait_n(8);
    endtask
endmodule
`default_nettype wire

// ### tb/sotp_tb_top.sv
// Testbench top: secured OTP, security register and protect-select checks
`default_nettype none
module secured_otp_and_protect_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sotp_pkg::*;

    localparam logic [7:0] EV [10] = '{8'h80, 8'h20, 8'h10, 8'h40, 8'h08, 8'h02, 8'h04,
                                       8'h01, 8'h90, 8'h10};
    localparam logic [7:0] EX [10] = '{8'h41, 8'h61, 8'h01, 8'h21, 8'h29, 8'h2D, 8'h25,
                                       8'h21, 8'h41, 8'h01};
    logic clk_i, nrst_i, cs_n, sclk, wp_n, quad_command_mode, write_enable_latch, bp_hit, sect_hit;
    logic otp_mode, otp_prog_ok, sect_en, array_wp, dyn_all, prog_otp_lockdown_bit, prog_protect_scheme_select, wel_clr;
    logic [3:0] host_sio, dev_sio, dev_oe, sio_w;
    logic [7:0] sec_reg;
    logic [15:0] rd;
    sotp_evt_s evt;
    sotp_nv_s nv;
    int failures, cmp_count, n_wel, n_otp_lockdown_bit, n_protect_scheme_select, n_dyn;

    // Wire level from the device enables; the host drives every line the device releases
    assign sio_w = (dev_oe & dev_sio) | (~dev_oe & host_sio);

    sotp_core sotp_core_i (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .sio_i(sio_w), .sio_o(dev_sio), .sio_oe_o(dev_oe), .wp_n_i(wp_n), .qpi_i(quad_command_mode),
        .wel_i(write_enable_latch), .evt_i(evt), .nv_i(nv), .bp_hit_i(bp_hit), .sect_hit_i(sect_hit),
        .otp_mode_o(otp_mode), .otp_prog_ok_o(otp_prog_ok), .sect_cmd_en_o(sect_en),
        .array_wp_o(array_wp), .dyn_lock_all_o(dyn_all), .nv_prog_otp_lockdown_bit_o(prog_otp_lockdown_bit),
        .nv_prog_protect_scheme_select_o(prog_protect_scheme_select), .wel_clr_o(wel_clr), .sec_reg_o(sec_reg));
    sotp_host_model sotp_host_model_i (.clk_i(clk_i), .qpi_i(quad_command_mode), .sio_i(sio_w),
        .cs_n_o(cs_n), .sclk_o(sclk), .sio_o(host_sio));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Stored bits, write-enable latch and pulse counters, as the rest of the chip
    always @(negedge clk_i) begin
        if (prog_otp_lockdown_bit === 1'b1) begin
            nv.lockdown <= 1'b1;
            n_otp_lockdown_bit++;
        end
        if (prog_protect_scheme_select === 1'b1) begin
            nv.protect_scheme_select <= 1'b1;
            n_protect_scheme_select++;
        end
        if (wel_clr === 1'b1) begin
            write_enable_latch <= 1'b0;
            n_wel++;
        end
        if (dyn_all === 1'b1) n_dyn++;
    end

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic do_reset;
        nrst_i = 1'b0;
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Flags through the engine events, read mid-way in both command modes
    task automatic t_events;
        for (int i = 0; i < 10; i++) begin
            if (i == 6) begin
                sotp_host_model_i.frame(OPC_SREAD, 0, 16, rd);
                chk_v(rd, 16'h2D2D);
                chk_v(16'(dev_oe), 16'h0000);
                quad_command_mode = 1'b1;
                sotp_host_model_i.frame(OPC_SREAD, 0, 4, rd);
                chk_v(rd, 16'h2D2D);
                quad_command_mode = 1'b0;
            end
            evt = sotp_evt_s'(EV[i]);
            @(negedge clk_i);
            evt = sotp_evt_s'(8'h00);
            repeat (2) @(negedge clk_i);
            chk_v(16'(sec_reg), 16'(EX[i]));
        end
    endtask

    // Enter and leave OTP mode; a two-byte frame is refused
    task automatic t_otp;
        sotp_host_model_i.frame(OPC_ENTER, 0, 0, rd);
        chk_b(otp_mode, 1'b1);
        chk_b(otp_prog_ok, 1'b1);
        quad_command_mode = 1'b1;
        sotp_host_model_i.frame(OPC_EXIT, 0, 0, rd);
        chk_b(otp_mode, 1'b0);
        quad_command_mode = 1'b0;
        sotp_host_model_i.frame(OPC_ENTER, 8, 0, rd);
        chk_b(otp_mode, 1'b0);
    endtask

    // Security write: no latch, off boundary, accepted, repeated
    task automatic t_swrite;
        sotp_host_model_i.frame(OPC_SWRITE, 0, 0, rd);
        chk_v(16'(sec_reg), 16'h0001);
        write_enable_latch = 1'b1;
        sotp_host_model_i.frame(OPC_SWRITE, 4, 0, rd);
        chk_v(16'(n_wel), 16'h0000);
        sotp_host_model_i.frame(OPC_SWRITE, 0, 0, rd);
        chk_v(16'(sec_reg), 16'h0003);
        chk_v(16'(n_otp_lockdown_bit), 16'h0001);
        write_enable_latch = 1'b1;
        sotp_host_model_i.frame(OPC_SWRITE, 0, 0, rd);
        chk_v(16'(n_otp_lockdown_bit), 16'h0001);
        chk_v(16'(n_wel), 16'h0002);
        sotp_host_model_i.frame(OPC_ENTER, 0, 0, rd);
        chk_b(otp_mode, 1'b1);
        chk_b(otp_prog_ok, 1'b0);
        sotp_host_model_i.frame(OPC_EXIT, 0, 0, rd);
    endtask

    // Protection scheme before and after the one-way select, then power cycle
    task automatic t_psel;
        bp_hit = 1'b1;
        repeat (3) @(negedge clk_i);
        chk_b(array_wp, 1'b1);
        bp_hit = 1'b0;
        sect_hit = 1'b1;
        repeat (3) @(negedge clk_i);
        chk_b(array_wp, 1'b0);
        sotp_host_model_i.frame(OPC_PSEL, 0, 0, rd);
        chk_v(16'(sec_reg), 16'h0003);
        chk_b(sect_en, 1'b0);
        write_enable_latch = 1'b1;
        sotp_host_model_i.frame(OPC_PSEL, 0, 0, rd);
        chk_v(16'(sec_reg), 16'h0083);
        chk_b(sect_en, 1'b1);
        chk_b(array_wp, 1'b1);
        bp_hit = 1'b1;
        sect_hit = 1'b0;
        repeat (3) @(negedge clk_i);
        chk_b(array_wp, 1'b0);
        wp_n = 1'b0;
        repeat (6) @(negedge clk_i);
        chk_b(array_wp, 1'b1);
        wp_n = 1'b1;
        write_enable_latch = 1'b1;
        sotp_host_model_i.frame(OPC_PSEL, 0, 0, rd);
        chk_v(16'(n_protect_scheme_select), 16'h0001);
        do_reset();
        chk_v(16'(n_dyn), 16'h0001);
        chk_v(16'(sec_reg), 16'h0083);
        chk_b(sect_en, 1'b1);
    endtask

    // Watchdog well beyond the few tens of microseconds the run needs
    initial begin
        #1000000;
        failures++;
        end_of_test();
    end

    initial begin
        nrst_i = 1'b0;
        wp_n = 1'b1;
        quad_command_mode = 1'b0;
        write_enable_latch = 1'b0;
        bp_hit = 1'b0;
        sect_hit = 1'b0;
        evt = sotp_evt_s'(8'h00);
        nv = sotp_nv_s'(3'b001);
        failures = 0;
        cmp_count = 0;
        n_wel = 0;
        n_otp_lockdown_bit = 0;
        n_protect_scheme_select = 0;
        n_dyn = 0;
        do_reset();
        chk_v(16'(sec_reg), 16'h0001);
        chk_b(otp_mode, 1'b0);
        t_events();
        t_otp();
        t_swrite();
        t_psel();
        end_of_test();
    end
endmodule
`default_nettype wire
